// ==== pkg/uhcp_pkg.sv ====
// Constants for the host capability parameters register bank.
// Assumes a 32-bit Avalon-MM slave port with byte addresses on a 10 MHz mclk.
package uhcp_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int CNT_W = 16;
   localparam int FL_W = 11;
   localparam int SEG_W = 12;

   // Byte offsets
   localparam logic [ADDR_W-1:0] CAP_PARAMS_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] CMD_OFS = 8'h20;
   localparam logic [ADDR_W-1:0] SEGMENT_OFS = 8'h30;
   localparam logic [ADDR_W-1:0] IGNORED_WR_OFS = 8'hF0;

   // Capability parameter field positions
   localparam int ADDR64_BIT = 0;
   localparam int PROG_FL_BIT = 1;
   localparam int PARK_BIT = 2;
   localparam int RSVD_BIT = 3;
   localparam int ISO_LSB = 4;
   localparam int ISO_MSB = 7;
   localparam int EXT_PTR_LSB = 8;
   localparam int EXT_PTR_MSB = 15;
   localparam int RSVD_LSB = 16;
   localparam int RSVD_MSB = 31;

   // Capability parameter field values
   localparam logic [7:0] EXT_PTR_VAL = 8'h68;
   localparam logic [3:0] ISO_VAL = 4'h7;
   localparam logic PARK_VAL = 1'b0;
   localparam logic PROG_FL_VAL = 1'b0;
   localparam logic ADDR64_VAL = 1'b1;
   localparam logic [DATA_W-1:0] CAP_PARAMS_VAL =
      {16'h0000, EXT_PTR_VAL, ISO_VAL, 1'b0, PARK_VAL, PROG_FL_VAL, ADDR64_VAL};
   localparam logic [DATA_W-1:0] CAP_PARAMS_DOC = 32'h0000_6871;

   // Command register layout
   localparam int RUN_BIT = 0;
   localparam int FLS_LSB = 2;
   localparam int FLS_MSB = 3;
   localparam logic [DATA_W-1:0] CMD_RESET = 32'h0008_0000;
   localparam logic [DATA_W-1:0] CMD_WMASK_BASE = 32'h00FF_0001;
   localparam logic [DATA_W-1:0] CMD_FLS_MASK = 32'h0000_000C;
   localparam logic [DATA_W-1:0] CMD_WMASK =
      PROG_FL_VAL ? (CMD_WMASK_BASE | CMD_FLS_MASK) : CMD_WMASK_BASE;

   // Upper pointer word: only address bits 43:32 exist
   localparam int ADDR_BITS = 44;
   localparam logic [DATA_W-1:0] SEG_WMASK = 32'h0000_0FFF;
   localparam logic [DATA_W-1:0] SEG_RESET = 32'h0000_0000;

   localparam logic [FL_W-1:0] FL_MAX = 11'h400;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

endpackage : uhcp_pkg

// ==== design/uhcp_reg_cell.sv ====
// One 32-bit software register with a write mask and byte enables.
// Assumes wr_en is a single-cycle strobe from the bus port on the same clock.
module uhcp_reg_cell
   import uhcp_pkg::*;
#(
   parameter logic [DATA_W-1:0] WMASK = '0,
   parameter logic [DATA_W-1:0] RESET_VAL = '0
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [BE_W-1:0] byteen,
   output logic [DATA_W-1:0] q
);

   typedef struct packed
   {
      logic [DATA_W-1:0] val;
   } uhcp_cell_st_t;

   uhcp_cell_st_t s_q;
   uhcp_cell_st_t s_d;
   logic [DATA_W-1:0] lane_mask;

   always_comb
   begin
      lane_mask = '0;
      for (int i = 0; i < BE_W; i++)
      begin
         lane_mask[i*8 +: 8] = {8{byteen[i]}};
      end
      s_d = s_q;
      // Masked-off bits keep their reset value forever
      if (wr_en)
      begin
         s_d.val = (s_q.val & ~(WMASK & lane_mask)) | (wdata & WMASK & lane_mask);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_q <= '{val: RESET_VAL};
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end

   assign q = s_q.val;

endmodule : uhcp_reg_cell

// ==== design/uhcp_avs_port.sv ====
// Avalon-MM slave handshake: one wait cycle, then a one-cycle acknowledge.
// Assumes the master holds its request until it samples waitrequest low.
module uhcp_avs_port
   import uhcp_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic read,
   input wire logic write,
   input wire logic [DATA_W-1:0] rdata_in,
   output logic waitrequest,
   output logic [DATA_W-1:0] readdata,
   output logic commit
);

   typedef struct packed
   {
      logic waitreq;
      logic [DATA_W-1:0] rdata;
   } uhcp_port_st_t;

   uhcp_port_st_t s_q;
   uhcp_port_st_t s_d;

   // Commit on the accepting edge so a stalled ce cannot lose a write
   assign commit = ce && (read || write) && s_q.waitreq;

   always_comb
   begin
      s_d = s_q;
      if (commit)
      begin
         s_d.waitreq = 1'b0;
         s_d.rdata = read ? rdata_in : '0;
      end
      else
      begin
         s_d.waitreq = 1'b1;
      end
   end

   // Waitrequest is stored as is, so the pin comes straight from a flop
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_q <= '{waitreq: 1'b1, rdata: '0};
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end

   assign waitrequest = s_q.waitreq;
   assign readdata = s_q.rdata;

endmodule : uhcp_avs_port

// ==== design/uhcp_cap_regs.sv ====
// Host capability parameters register with its command and pointer segment.
// Assumes one Avalon-MM master on mclk; all inputs are on the mclk domain.
//
// Chosen here: the Avalon-MM register port.

// Summary of operation
// - Capability parameters word at offset 08h always reads 00006871h.
// - Bits 15:8 hold extended capability pointer 68h into configuration space.
// - Bits 7:4 hold isochronous scheduling threshold 7h.
// - Bit 2 reads 0: asynchronous schedule park is not supported.
// - Bit 1 zero means 1024-entry frame list; command size field stays zero.
// - Bit 0 reads 1: software builds structures with 64-bit pointers.
// - Only 44 address bits exist; pointer bits 63:44 read as zero.
// - Bit 3 and bits 31:16 are reserved and read zero.
module uhcp_cap_regs
   import uhcp_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [BE_W-1:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   output logic run_enable,
   output logic [FL_W-1:0] frame_list_len,
   output logic [SEG_W-1:0] ptr_segment_hi
);

   typedef struct packed
   {
      logic [CNT_W-1:0] ign_cnt;
      logic [FL_W-1:0] fl_len;
   } uhcp_top_st_t;

   uhcp_top_st_t s_q;
   uhcp_top_st_t s_d;
   logic commit;
   logic [DATA_W-1:0] rd_mux;
   logic [DATA_W-1:0] cmd_q;
   logic [DATA_W-1:0] seg_q;
   logic wr_cmd;
   logic wr_seg;
   logic wr_ignored;
   logic [1:0] fls;

   uhcp_avs_port u_port
   (
      .mclk(mclk),
      .reset(reset),
      .ce(ce),
      .read(avs_read),
      .write(avs_write),
      .rdata_in(rd_mux),
      .waitrequest(avs_waitrequest),
      .readdata(avs_readdata),
      .commit(commit)
   );

   // Read decode; unmapped offsets answer zero
   always_comb
   begin
      unique case (avs_address)
         CAP_PARAMS_OFS: rd_mux = CAP_PARAMS_VAL;
         CMD_OFS: rd_mux = cmd_q;
         SEGMENT_OFS: rd_mux = seg_q;
         IGNORED_WR_OFS: rd_mux = {{(DATA_W-CNT_W){1'b0}}, s_q.ign_cnt};
         default: rd_mux = '0;
      endcase
   end

   assign wr_cmd = commit && avs_write && (avs_address == CMD_OFS);
   assign wr_seg = commit && avs_write && (avs_address == SEGMENT_OFS);
   // Capability word and unmapped space swallow writes; counted for debug
   assign wr_ignored = commit && avs_write && !wr_cmd && !wr_seg
      && (avs_address != IGNORED_WR_OFS);

   // Size field bits are outside the write mask while the list is fixed
   uhcp_reg_cell #(.WMASK(CMD_WMASK), .RESET_VAL(CMD_RESET)) u_cmd
   (
      .mclk(mclk),
      .reset(reset),
      .ce(ce),
      .wr_en(wr_cmd),
      .wdata(avs_writedata),
      .byteen(avs_byteenable),
      .q(cmd_q)
   );

   // Upper pointer word keeps only the implemented address bits
   uhcp_reg_cell #(.WMASK(SEG_WMASK), .RESET_VAL(SEG_RESET)) u_seg
   (
      .mclk(mclk),
      .reset(reset),
      .ce(ce),
      .wr_en(wr_seg),
      .wdata(avs_writedata),
      .byteen(avs_byteenable),
      .q(seg_q)
   );

   assign fls = cmd_q[FLS_MSB:FLS_LSB];

   always_comb
   begin
      s_d = s_q;
      if (wr_ignored)
      begin
         s_d.ign_cnt = s_q.ign_cnt + CNT_ONE;
      end
      // Fixed 1024 entries unless the list length is programmable
      if (PROG_FL_VAL)
      begin
         s_d.fl_len = FL_MAX >> fls;
      end
      else
      begin
         s_d.fl_len = FL_MAX;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_q <= '{ign_cnt: '0, fl_len: FL_MAX};
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end

   assign run_enable = cmd_q[RUN_BIT];
   assign frame_list_len = s_q.fl_len;
   assign ptr_segment_hi = seg_q[SEG_W-1:0];

   // Checks on the capability word as seen on the bus, on the features its fields describe, and on the acknowledge pulse

   cap_value_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && avs_read && avs_waitrequest && avs_address == CAP_PARAMS_OFS
      |=> !avs_waitrequest && avs_readdata == CAP_PARAMS_DOC)
      else $error("capability word read back wrong");

   ext_pointer_a: assert property (
      @(posedge mclk) disable iff (reset)
      !avs_waitrequest && $past(avs_read) && $past(ce)
      && $past(avs_waitrequest) && $past(avs_address) == CAP_PARAMS_OFS
      |-> avs_readdata[EXT_PTR_MSB:EXT_PTR_LSB] == EXT_PTR_VAL)
      else $error("extended capability pointer wrong");

   iso_threshold_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && commit && avs_read && avs_address == CAP_PARAMS_OFS
      ##1 1'b1
      |-> avs_readdata[ISO_MSB:ISO_LSB] == ISO_VAL)
      else $error("isochronous threshold wrong");

   park_bit_a: assert property (
      @(posedge mclk) disable iff (reset)
      commit && avs_read && avs_address == CAP_PARAMS_OFS
      |=> avs_readdata[PARK_BIT] == 1'b0 && avs_readdata[PROG_FL_BIT] == PROG_FL_VAL)
      else $error("park or frame list flag wrong");

   fixed_list_a: assert property (
      @(posedge mclk) disable iff (reset)
      wr_cmd && avs_writedata[FLS_MSB:FLS_LSB] != 2'b00
      |=> (PROG_FL_VAL || cmd_q[FLS_MSB:FLS_LSB] == 2'b00)
      ##1 (PROG_FL_VAL || frame_list_len == FL_MAX))
      else $error("frame list size field not fixed");

   addr64_bit_a: assert property (
      @(posedge mclk) disable iff (reset)
      commit && avs_read && avs_address == CAP_PARAMS_OFS
      |=> avs_readdata[ADDR64_BIT] == 1'b1 && !avs_waitrequest)
      else $error("64-bit capability bit wrong");

   seg_upper_a: assert property (
      @(posedge mclk) disable iff (reset)
      wr_seg && avs_byteenable == 4'hF
      |=> seg_q[DATA_W-1:SEG_W] == '0
      && seg_q[SEG_W-1:0] == $past(avs_writedata[SEG_W-1:0]))
      else $error("pointer segment upper bits not zero");

   reserved_bits_a: assert property (
      @(posedge mclk) disable iff (reset)
      commit && avs_read && avs_address == CAP_PARAMS_OFS
      |=> avs_readdata[RSVD_MSB:RSVD_LSB] == '0 && avs_readdata[RSVD_BIT] == 1'b0)
      else $error("reserved bits not zero");

   ro_write_a: assert property (
      @(posedge mclk) disable iff (reset)
      commit && avs_write && avs_address == CAP_PARAMS_OFS
      |=> $stable(cmd_q) && $stable(seg_q)
      && s_q.ign_cnt == $past(s_q.ign_cnt) + CNT_ONE)
      else $error("write to capability word had an effect");

   ack_pulse_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && !avs_waitrequest |=> avs_waitrequest)
      else $error("acknowledge longer than one cycle");

   // Handshake, hold and reset checks

   accept_ack_a: assert property (
      @(posedge mclk) disable iff (reset)
      !reset && ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("accepted request not acknowledged next cycle");

   idle_wait_a: assert property (
      @(posedge mclk) disable iff (reset)
      !reset && avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest)
      else $error("acknowledge without a request");

   ce_freeze_a: assert property (
      @(posedge mclk) disable iff (reset)
      !reset && !ce |=> $stable(avs_waitrequest) && $stable(avs_readdata)
      && $stable(cmd_q) && $stable(seg_q) && $stable(s_q))
      else $error("state moved while clock enable low");

   unmapped_read_a: assert property (
      @(posedge mclk) disable iff (reset)
      commit && avs_read && avs_address != CAP_PARAMS_OFS && avs_address != CMD_OFS
      && avs_address != SEGMENT_OFS && avs_address != IGNORED_WR_OFS
      |=> avs_readdata == '0)
      else $error("unmapped offset read not zero");

   write_rdata_a: assert property (
      @(posedge mclk) disable iff (reset)
      commit && avs_write |=> avs_readdata == '0 && !avs_waitrequest)
      else $error("write answered with data");

   rdata_stand_a: assert property (
      @(posedge mclk) disable iff (reset)
      !reset && !commit |=> $stable(avs_readdata))
      else $error("read data changed without a request");

   seg_read_a: assert property (
      @(posedge mclk) disable iff (reset)
      commit && avs_read && avs_address == SEGMENT_OFS
      |=> avs_readdata[DATA_W-1:SEG_W] == '0)
      else $error("unimplemented address bits read back");

   seg_hold_a: assert property (
      @(posedge mclk) disable iff (reset)
      !reset && !wr_seg |=> $stable(seg_q))
      else $error("pointer segment changed without a write");

   seg_unused_a: assert property (
      @(posedge mclk) disable iff (reset)
      (seg_q & ~SEG_WMASK) == '0)
      else $error("pointer segment holds bits above address 43");

   seg_out_a: assert property (
      @(posedge mclk) disable iff (reset)
      wr_seg && avs_byteenable == '1 |=> ptr_segment_hi == $past(avs_writedata[SEG_W-1:0]))
      else $error("pointer segment output wrong");

   cmd_hold_a: assert property (
      @(posedge mclk) disable iff (reset)
      !reset && !wr_cmd |=> $stable(cmd_q))
      else $error("command register changed without a write");

   cmd_fixed_a: assert property (
      @(posedge mclk) disable iff (reset)
      (cmd_q & ~CMD_WMASK) == (CMD_RESET & ~CMD_WMASK))
      else $error("read-only command bits moved");

   ign_hold_a: assert property (
      @(posedge mclk) disable iff (reset)
      !reset && !wr_ignored |=> $stable(s_q.ign_cnt))
      else $error("ignored-write counter moved without a write");

   ign_count_a: assert property (
      @(posedge mclk) disable iff (reset)
      wr_ignored |=> s_q.ign_cnt == $past(s_q.ign_cnt) + CNT_ONE)
      else $error("ignored write not counted");

   ro_effect_a: assert property (
      @(posedge mclk) disable iff (reset)
      commit && avs_write && avs_address != CMD_OFS && avs_address != SEGMENT_OFS
      |=> $stable(cmd_q) && $stable(seg_q) && $stable(run_enable) && $stable(ptr_segment_hi))
      else $error("write to a read-only offset had an effect");

   fl_fixed_a: assert property (
      @(posedge mclk) disable iff (reset)
      !PROG_FL_VAL |-> frame_list_len == FL_MAX && cmd_q[FLS_MSB:FLS_LSB] == '0)
      else $error("frame list length not fixed");

   run_follow_a: assert property (
      @(posedge mclk) disable iff (reset)
      wr_cmd && avs_byteenable == '1 |=> run_enable == $past(avs_writedata[RUN_BIT]))
      else $error("run enable does not follow command write");

   cap_mux_a: assert property (
      @(posedge mclk) disable iff (reset)
      avs_address == CAP_PARAMS_OFS |-> rd_mux == CAP_PARAMS_DOC)
      else $error("capability word selected wrong");

   reset_values_a: assert property (
      @(posedge mclk)
      reset |=> avs_waitrequest && avs_readdata == '0 && !run_enable
      && frame_list_len == FL_MAX && ptr_segment_hi == '0
      && cmd_q == CMD_RESET && seg_q == SEG_RESET && s_q.ign_cnt == '0)
      else $error("register not at its reset value");

endmodule : uhcp_cap_regs

// ==== sim/usb_host_capability_params_tb.sv ====
// Self-checking bench for the capability parameters register bank.
// Assumes uhcp_pkg is compiled first and the bench is the only bus master.
module usb_host_capability_params_tb
   import uhcp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {
      logic wr;
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
      logic [BE_W-1:0] be;
      logic [DATA_W-1:0] exp;
   } uhcp_row_t;

`define CHK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
      end \
   end

   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic [ADDR_W-1:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = 32'h0000_0000;
   logic [BE_W-1:0] avs_byteenable = 4'h0;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic run_enable;
   logic [FL_W-1:0] frame_list_len;
   logic [SEG_W-1:0] ptr_segment_hi;
   int miscompares = 0;
   int check_count = 0;
   logic [DATA_W-1:0] rd;
   uhcp_row_t rows [14];

   always #50 mclk = ~mclk;

   uhcp_cap_regs u_dut (
      .mclk(mclk),
      .reset(reset),
      .ce(ce),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .run_enable(run_enable),
      .frame_list_len(frame_list_len),
      .ptr_segment_hi(ptr_segment_hi)
   );

   // Idle edge after release, so back-to-back calls never drive twice at once
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be,
                      output logic [DATA_W-1:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && n < 100)
      begin
         n++;
         @(posedge mclk);
      end
      if (n >= 100)
      begin
         miscompares++;
         $display("ERROR at %0t: no bus answer", $time);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic report_and_stop;
      $display("Mismatches %0d of %0d checks", miscompares, check_count);
      if (miscompares == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   initial
   begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      report_and_stop();
   end

   initial
   begin
      rows = '{
         '{1'b0, 8'h08, 32'h0000_0000, 4'hF, 32'h0000_6871},
         '{1'b1, 8'h08, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000},
         '{1'b0, 8'h08, 32'h0000_0000, 4'hF, 32'h0000_6871},
         '{1'b0, 8'h20, 32'h0000_0000, 4'hF, 32'h0008_0000},
         '{1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000},
         '{1'b0, 8'h20, 32'h0000_0000, 4'hF, 32'h00FF_0001},
         '{1'b1, 8'h30, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000},
         '{1'b0, 8'h30, 32'h0000_0000, 4'hF, 32'h0000_0FFF},
         '{1'b0, 8'h44, 32'h0000_0000, 4'hF, 32'h0000_0000},
         '{1'b1, 8'h44, 32'h1234_5678, 4'hF, 32'h0000_0000},
         '{1'b1, 8'hF0, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000},
         '{1'b0, 8'hF0, 32'h0000_0000, 4'hF, 32'h0000_0002},
         '{1'b1, 8'h30, 32'h0000_0000, 4'h1, 32'h0000_0000},
         '{1'b0, 8'h30, 32'h0000_0000, 4'hF, 32'h0000_0F00}
      };
      repeat (16) @(posedge mclk);
      `CHK(avs_waitrequest, 1'b1)
      `CHK(frame_list_len, 11'h400)
      `CHK(ptr_segment_hi, 12'h000)
      reset <= 1'b0;
      @(posedge mclk);
      for (int i = 0; i < 14; i++)
      begin
         bus(rows[i].wr, rows[i].a, rows[i].d, rows[i].be, rd);
         if (!rows[i].wr)
            `CHK(rd, rows[i].exp)
      end
      `CHK(run_enable, 1'b1)
      `CHK(frame_list_len, 11'h400)
      // 1024 four-byte entries fill exactly one 4K page
      `CHK({frame_list_len, 2'b00}, 13'h1000)
      `CHK(ptr_segment_hi, 12'hF00)
      bus(1'b0, 8'h08, 32'h0000_0000, 4'hF, rd);
      `CHK(rd[15:8], 8'h68)
      `CHK(rd[7:4], 4'h7)
      `CHK(rd[7], 1'b0)
      `CHK(rd[6:4], 3'h7)
      `CHK(rd[2], 1'b0)
      `CHK(rd[1], 1'b0)
      `CHK(rd[0], 1'b1)
      `CHK({rd[31:16], rd[3]}, 17'h0_0000)
      // Stalled clock enable must hold the answer back
      ce <= 1'b0;
      fork
         bus(1'b0, 8'h08, 32'h0000_0000, 4'hF, rd);
         begin
            repeat (3) @(posedge mclk);
            `CHK(avs_waitrequest, 1'b1)
            ce <= 1'b1;
         end
      join
      `CHK(rd, 32'h0000_6871)
      // Reset in mid-run restores the writable registers, not the constant
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK(run_enable, 1'b0)
      reset <= 1'b0;
      @(posedge mclk);
      bus(1'b0, 8'h20, 32'h0000_0000, 4'hF, rd);
      `CHK(rd, 32'h0008_0000)
      bus(1'b0, 8'h30, 32'h0000_0000, 4'hF, rd);
      `CHK(rd, 32'h0000_0000)
      bus(1'b0, 8'hF0, 32'h0000_0000, 4'hF, rd);
      `CHK(rd, 32'h0000_0000)
      bus(1'b0, 8'h08, 32'h0000_0000, 4'hF, rd);
      `CHK(rd, 32'h0000_6871)
      report_and_stop();
   end

endmodule : usb_host_capability_params_tb
